// ---- pixel_exposure_consts.svh ----
`ifndef PIXEL_EXPOSURE_CONSTS_SVH
`define PIXEL_EXPOSURE_CONSTS_SVH
`define ADDR_PIXEL_DATA 8'h08
`define ADDR_EXPOSURE_HIGH 8'h09
`define ADDR_EXPOSURE_LOW 8'h0a
`define ADDR_TYPE_COMPLEMENT 8'h11
`define EXPOSURE_RESET 16'h0100
`define EXPOSURE_CEILING 16'h306d
`define EXPOSURE_FLOOR 16'h0010
`define BRIGHT_HIGH 6'h3a
`define BRIGHT_LOW 6'h34
`define PIXELS_PER_COLUMN 5'h12
`define COLUMN_COUNT 5'h12
`define PIXEL_COUNT 9'h144
`define FIRST_PIXEL 9'h001
`define RESERVED_NIBBLE 4'hf
`define BIT_FRAME_START 7
`define BIT_DATA_VALID 6
`endif

// ---- pixel_exposure_pkg.sv ----
package pixel_exposure_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_t;

  typedef struct packed {
    logic frameStart;
    logic dataValid;
    logic [5:0] value;
  } pixelWord_t;
endpackage : pixel_exposure_pkg

// ---- exposure_stepper.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pixel_exposure_consts.svh"
module exposure_stepper #(
  parameter logic [15:0] CEILING = `EXPOSURE_CEILING,
  parameter logic [15:0] FLOOR = `EXPOSURE_FLOOR,
  parameter logic [5:0] HIGH = `BRIGHT_HIGH,
  parameter logic [5:0] LOW = `BRIGHT_LOW
) (
  input wire logic [15:0] count,
  input wire logic [5:0] brightest,
  output logic [15:0] nextCount
);
  wire logic [15:0] step;
  wire logic [16:0] upSum;
  wire logic [15:0] upCapped;
  wire logic [15:0] downDiff;
  wire logic [15:0] downHeld;
  wire logic tooBright;
  wire logic tooDark;

  // Never a zero step, or small counts would stall
  assign step = (count[15:4] == 12'h000) ? 16'h0001 : {4'h0, count[15:4]};
  assign upSum = {1'b0, count} + {1'b0, step};
  assign upCapped = (upSum > {1'b0, CEILING}) ? CEILING : upSum[15:0];
  assign downDiff = count - step;
  assign downHeld = (count < FLOOR + step) ? FLOOR : downDiff;
  assign tooBright = brightest > HIGH;
  assign tooDark = brightest < LOW;
  assign nextCount = tooBright ? downHeld : (tooDark ? upCapped : count);
endmodule : exposure_stepper
`default_nettype wire

// ---- pixel_exposure_readout.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pixel_exposure_consts.svh"
module pixel_exposure_readout #(
  parameter logic [3:0] TYPE_CODE = 4'h5, // Arbitrary value
  parameter logic [15:0] CEILING = `EXPOSURE_CEILING
) (
  input wire logic mclk,
  input wire logic reset,
  input wire pixel_exposure_pkg::regReq_t req,
  output logic [7:0] rdData,
  output logic rdValid,
  input wire logic pixStrobe,
  input wire logic pixFirst,
  input wire logic [5:0] pixValue,
  output logic [15:0] exposureCount
);
  logic [4:0] row_ff;
  logic [4:0] col_ff;
  logic [5:0] frameMax_ff;
  logic [15:0] exposure_ff;
  logic [8:0] pointer_ff;
  logic armed_ff;
  pixel_exposure_pkg::pixelWord_t grab_ff;
  logic [7:0] lowSnap_ff;
  logic [7:0] rdData_ff;
  logic rdValid_ff;

  wire logic [4:0] rowHere;
  wire logic [4:0] colHere;
  wire logic [8:0] pixelNumber;
  wire logic lastPixel;
  wire logic [5:0] maxSoFar;
  wire logic [5:0] maxWithThis;
  wire logic [15:0] nxt_exposure;
  wire logic selPixel;
  wire logic selHigh;
  wire logic selLow;
  wire logic selType;
  wire logic pixelRead;
  wire logic pixelWrite;
  wire logic takeValid;
  wire logic grabNow;
  wire logic [8:0] nxt_pointer;
  wire logic [7:0] nxt_rdData;

  // A first-pixel strobe restarts numbering whatever went before
  assign rowHere = pixFirst ? 5'h00 : row_ff;
  assign colHere = pixFirst ? 5'h00 : col_ff;
  // Column-major numbering: 18 per column from the first corner
  assign pixelNumber = 9'(colHere) * 9'(`PIXELS_PER_COLUMN) + 9'(rowHere)
    + `FIRST_PIXEL;
  assign lastPixel = pixelNumber == `PIXEL_COUNT;
  assign maxSoFar = pixFirst ? 6'h00 : frameMax_ff;
  assign maxWithThis = (pixValue > maxSoFar) ? pixValue : maxSoFar;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      row_ff <= 5'h00;
      col_ff <= 5'h00;
      frameMax_ff <= 6'h00;
    end
    else if (pixStrobe)
    begin
      frameMax_ff <= maxWithThis;
      if (rowHere == `PIXELS_PER_COLUMN - 5'h01)
      begin
        row_ff <= 5'h00;
        col_ff <= (colHere == `COLUMN_COUNT - 5'h01) ? 5'h00
          : colHere + 5'h01;
      end
      else
      begin
        row_ff <= rowHere + 5'h01;
        col_ff <= colHere;
      end
    end
  end

  exposure_stepper #(
    .CEILING(CEILING),
    .FLOOR(`EXPOSURE_FLOOR),
    .HIGH(`BRIGHT_HIGH),
    .LOW(`BRIGHT_LOW)
  ) stepper (
    .count(exposure_ff),
    .brightest(maxWithThis),
    .nextCount(nxt_exposure)
  );

  // Loop acts once per frame, on the last pixel's strobe
  always_ff @(posedge mclk)
  begin
    if (reset)
      exposure_ff <= `EXPOSURE_RESET;
    else if (pixStrobe && lastPixel)
      exposure_ff <= nxt_exposure;
  end
  assign exposureCount = exposure_ff;

  assign selPixel = req.addr == `ADDR_PIXEL_DATA;
  assign selHigh = req.addr == `ADDR_EXPOSURE_HIGH;
  assign selLow = req.addr == `ADDR_EXPOSURE_LOW;
  assign selType = req.addr == `ADDR_TYPE_COMPLEMENT;
  assign pixelRead = req.rd && selPixel;
  assign pixelWrite = req.wr && selPixel;
  // Only a read that delivered valid data moves to the next pixel
  assign takeValid = pixelRead && grab_ff.dataValid;
  assign nxt_pointer = (pointer_ff == `PIXEL_COUNT) ? `FIRST_PIXEL
    : pointer_ff + 9'h001;
  // Armed pixel is caught from the next frame that passes it
  assign grabNow = armed_ff && pixStrobe && pixelNumber == pointer_ff;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pointer_ff <= `FIRST_PIXEL;
      armed_ff <= 1'b1;
      grab_ff <= '0;
    end
    else if (pixelWrite)
    begin
      pointer_ff <= `FIRST_PIXEL;
      armed_ff <= 1'b1;
      grab_ff <= '0;
    end
    else if (takeValid)
    begin
      pointer_ff <= nxt_pointer;
      armed_ff <= 1'b1;
      grab_ff <= '0;
    end
    else if (grabNow)
    begin
      armed_ff <= 1'b0;
      grab_ff.frameStart <= pointer_ff == `FIRST_PIXEL;
      grab_ff.dataValid <= 1'b1;
      grab_ff.value <= pixValue;
    end
  end

  // Low byte answers from the snapshot so the pair stays coherent
  always_ff @(posedge mclk)
  begin
    if (reset)
      lowSnap_ff <= 8'(`EXPOSURE_RESET & 16'h00ff);
    else if (req.rd && selHigh)
      lowSnap_ff <= exposure_ff[7:0];
  end

  assign nxt_rdData = selPixel ? grab_ff
    : selHigh ? exposure_ff[15:8]
    : selLow ? lowSnap_ff
    : selType ? {`RESERVED_NIBBLE, ~TYPE_CODE}
    : 8'h00;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      rdData_ff <= 8'h00;
      rdValid_ff <= 1'b0;
    end
    else
    begin
      rdValid_ff <= req.rd;
      if (req.rd)
        rdData_ff <= nxt_rdData;
    end
  end
  assign rdData = rdData_ff;
  assign rdValid = rdValid_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  write_rearms_a: assert property (
    pixelWrite |=> pointer_ff == `FIRST_PIXEL && armed_ff
      && !grab_ff.dataValid)
    else $error("Pixel write did not rearm to pixel one");
  first_sof_a: assert property (
    grabNow && pointer_ff == `FIRST_PIXEL && !pixelWrite && !takeValid
      |=> grab_ff.frameStart && grab_ff.dataValid)
    else $error("Pixel one captured without frame start");
  one_grab_a: assert property (
    grab_ff.dataValid && !pixelWrite && !takeValid
      |=> grab_ff.dataValid && $stable(grab_ff.value))
    else $error("Held pixel changed before being read");
  ceiling_hold_a: assert property (
    exposure_ff <= CEILING || exposure_ff == `EXPOSURE_RESET)
    else $error("Exposure exceeded ceiling");
  step_size_a: assert property (
    pixStrobe && lastPixel && nxt_exposure != exposure_ff
      && nxt_exposure != CEILING && nxt_exposure != `EXPOSURE_FLOOR
      |=> (exposure_ff == $past(exposure_ff) + $past(exposure_ff) / 16)
        || (exposure_ff == $past(exposure_ff) - $past(exposure_ff) / 16))
    else $error("Exposure step not one sixteenth");
  bright_down_a: assert property (
    pixStrobe && lastPixel && maxWithThis > `BRIGHT_HIGH
      && exposure_ff > `EXPOSURE_FLOOR |=> exposure_ff < $past(exposure_ff))
    else $error("Bright frame did not shorten exposure");
  pair_match_a: assert property (
    req.rd && selHigh ##1 req.rd && selLow
      |=> rdData == $past(exposure_ff[7:0], 2))
    else $error("Low byte not from high byte sample");
  type_read_a: assert property (
    req.rd && selType |=> rdValid && rdData[3:0] == ~TYPE_CODE)
    else $error("Type register wrong");
  order_col_a: assert property (
    pixStrobe && !pixFirst && row_ff == 5'h11 |=> row_ff == 5'h00)
    else $error("Column did not end after 18 pixels");

  dump_wrap_c: cover property (takeValid && pointer_ff == `PIXEL_COUNT);
  exposure_cap_c: cover property (exposure_ff == CEILING);
  pair_read_c: cover property (req.rd && selHigh ##1 req.rd && selLow);
endmodule : pixel_exposure_readout
`default_nettype wire

// ---- pixel_source_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module pixel_source_model (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] peak,
  output logic pixStrobe,
  output logic pixFirst,
  output logic [5:0] pixValue,
  output logic lastPix
);
  logic [8:0] num;
  // Pixel 7n mod 64 clipped at peak, so every frame's brightest equals peak
  function automatic logic [5:0] shade(input int n, input logic [5:0] p);
    logic [5:0] v;
    v = 6'(n * 7);
    shade = (v > p) ? p : v;
  endfunction : shade
  initial {pixStrobe, pixFirst, lastPix, pixValue} = '0;
  always @(posedge mclk)
  begin
    pixStrobe <= !reset;
    pixFirst <= !reset && num == 9'h001;
    lastPix <= !reset && num == 9'h144;
    pixValue <= shade(int'(num), peak);
    if (reset)
      num <= 9'h001;
    else
      num <= (num == 9'h144) ? 9'h001 : num + 9'h001;
  end
endmodule : pixel_source_model
`default_nettype wire

// ---- pixel_exposure_readout_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pixel_exposure_consts.svh"
module pixel_exposure_readout_tb;
  // Low ceiling so the clamp is reached within a few frames
  localparam logic [15:0] CEIL = 16'h0180;
  localparam logic [3:0] TYPE = 4'h9; // Arbitrary value
  logic mclk = 1'b0;
  logic reset = 1'b1;
  pixel_exposure_pkg::regReq_t req = '0;
  logic [7:0] rdData;
  logic rdValid;
  logic pixStrobe;
  logic pixFirst;
  logic lastPix;
  logic [5:0] pixValue;
  logic [5:0] peak = 6'h37;
  logic [15:0] exposureCount;
  logic [15:0] expo = `EXPOSURE_RESET;
  logic chk = 1'b0;
  logic [7:0] q[$];
  int n_errors = 0;
  int checked = 0;
  always #10 mclk = ~mclk;
  pixel_exposure_readout #(.TYPE_CODE(TYPE), .CEILING(CEIL)) dut (
    .mclk(mclk), .reset(reset), .req(req), .rdData(rdData),
    .rdValid(rdValid), .pixStrobe(pixStrobe), .pixFirst(pixFirst),
    .pixValue(pixValue), .exposureCount(exposureCount));
  pixel_source_model src (.mclk(mclk), .reset(reset), .peak(peak),
    .pixStrobe(pixStrobe), .pixFirst(pixFirst), .pixValue(pixValue),
    .lastPix(lastPix));
  function automatic logic [15:0] nxt(input logic [15:0] c,
    input logic [5:0] p);
    logic [15:0] s;
    s = (c[15:4] == 12'h000) ? 16'h0001 : c >> 4;
    nxt = c;
    if (p > `BRIGHT_HIGH)
      nxt = (c - s < `EXPOSURE_FLOOR) ? `EXPOSURE_FLOOR : c - s;
    else if (p < `BRIGHT_LOW)
      nxt = (c + s > CEIL) ? CEIL : c + s;
  endfunction : nxt
  task automatic cmp(input string what, input logic [15:0] e,
    input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp
  task automatic cmp_read(input logic [7:0] e, input logic [7:0] g);
    cmp("rdData", {8'h00, e}, {8'h00, g});
  endtask : cmp_read
  task automatic conclude();
    $display("Errors %0d, checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic note(input logic [7:0] e);
    q.push_back(e);
  endtask : note
  task automatic acc(input logic r, input logic [7:0] a, input logic [7:0] d);
    req <= '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge mclk);
  endtask : acc
  task automatic idle();
    req <= '0;
    @(posedge mclk);
  endtask : idle
  // Peak changes only at a frame end so a frame never mixes two peaks
  task automatic frames(input int n, input logic [5:0] p);
    int t;
    repeat (n)
    begin
      t = 0;
      do
      begin
        @(posedge mclk);
        t++;
      end while (lastPix !== 1'b1 && t < 400);
      if (t >= 400)
      begin
        n_errors++;
        conclude();
      end
    end
    peak <= p;
  endtask : frames
  task automatic rdexp();
    idle();
    note(expo[15:8]);
    note(expo[7:0]);
    acc(1'b1, `ADDR_EXPOSURE_HIGH, 8'h00);
    acc(1'b1, `ADDR_EXPOSURE_LOW, 8'h00);
    idle();
  endtask : rdexp
  always @(posedge mclk)
  begin
    chk <= lastPix;
    if (chk)
      cmp("exposureCount", expo, exposureCount);
    if (lastPix)
      expo <= nxt(expo, peak);
    if (rdValid === 1'b1)
      cmp_read(q.size() > 0 ? q.pop_front() : 8'hxx, rdData);
  end
  initial
  begin
    void'($urandom(7901));
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    cmp("exposureCount", `EXPOSURE_RESET, exposureCount);
    note(8'h00);
    acc(1'b1, `ADDR_EXPOSURE_LOW, 8'h00);
    note({`RESERVED_NIBBLE, ~TYPE});
    acc(1'b1, `ADDR_TYPE_COMPLEMENT, 8'h00);
    acc(1'b0, `ADDR_TYPE_COMPLEMENT, 8'($urandom));
    note({`RESERVED_NIBBLE, ~TYPE});
    acc(1'b1, `ADDR_TYPE_COMPLEMENT, 8'h00);
    note(8'h00);
    acc(1'b1, {4'h3, 4'($urandom)}, 8'h00);
    acc(1'b0, `ADDR_PIXEL_DATA, 8'($urandom));
    idle();
    for (int k = 1; k <= 20; k++)
    begin
      frames(2, 6'(52 + $urandom % 7));
      note({k == 1, 1'b1, (6'(k * 7) > peak) ? peak : 6'(k * 7)});
      acc(1'b1, `ADDR_PIXEL_DATA, 8'h00);
      idle();
    end
    acc(1'b0, `ADDR_PIXEL_DATA, 8'($urandom));
    idle();
    frames(2, 6'h28);
    note(8'hc7);
    acc(1'b1, `ADDR_PIXEL_DATA, 8'h00);
    idle();
    frames(8, 6'h3f);
    rdexp();
    cmp("ceiling", CEIL, exposureCount);
    frames(3, 6'h37);
    rdexp();
    // Let the last answer reach the watcher before the count
    idle();
    cmp("pending", 16'h0000, 16'(q.size()));
    conclude();
  end
endmodule : pixel_exposure_readout_tb
`default_nettype wire
